// file: rtl/sdhcs_pkg.sv
// Package for the servo drive command and status block: register map,
// field positions, command codes and timing counts.
// Assumes a single 40 MHz clock shared by the APB side and the serial link.
package sdhcs_pkg;
	// Clock and timing
	localparam int SDHCS_CLK_MHZ = 40;
	localparam int SDHCS_TICK_NS = 51200;
	localparam int SDHCS_TICK_CYC = (SDHCS_TICK_NS * SDHCS_CLK_MHZ) / 1000;
	localparam int SDHCS_BIT_NS = 800;
	localparam int SDHCS_BIT_CYC = (SDHCS_BIT_NS * SDHCS_CLK_MHZ) / 1000;
	localparam int SDHCS_HALF_CYC = SDHCS_BIT_CYC / 2;

	// Packet framing
	localparam logic [7:0] SDHCS_HEADER = 8'haa;
	localparam logic [7:0] SDHCS_ADDR_ALL = 8'hff;
	localparam logic [7:0] SDHCS_GROUP_BASE = 8'h80;
	localparam logic [3:0] SDHCS_CMD_LOAD_TRAJ = 4'h4;
	localparam logic [3:0] SDHCS_CMD_STOP = 4'h7;
	localparam logic [3:0] SDHCS_CMD_HOMING = 4'h9;
	localparam logic [3:0] SDHCS_CMD_CLR_STICKY = 4'hb;
	localparam logic [3:0] SDHCS_CMD_PATH = 4'hd;
	localparam logic [3:0] SDHCS_CMD_HARD_RESET = 4'hf;

	// Register byte offsets
	localparam logic [11:0] SDHCS_REG_STATUS = 12'h000;
	localparam logic [11:0] SDHCS_REG_ADDR = 12'h004;
	localparam logic [11:0] SDHCS_REG_DIAG = 12'h008;
	localparam logic [11:0] SDHCS_REG_CMD = 12'h00c;
	localparam logic [11:0] SDHCS_REG_DATA0 = 12'h010;
	localparam logic [11:0] SDHCS_REG_DATA3 = 12'h01c;

	// Reset values
	localparam logic [15:0] SDHCS_ADDR_RST = 16'h0000;
	localparam logic [4:0] SDHCS_DIAG_RST = 5'h00;

	// Status byte bits
	localparam int SDHCS_ST_MOTION_DONE = 0;
	localparam int SDHCS_ST_CKSUM = 1;
	localparam int SDHCS_ST_OVERCURRENT = 2;
	localparam int SDHCS_ST_POWER = 3;
	localparam int SDHCS_ST_FOLLOW_ERR = 4;
	localparam int SDHCS_ST_HOME_SRC = 5;
	localparam int SDHCS_ST_LIMIT_FWD = 6;
	localparam int SDHCS_ST_HOMING = 7;
	// Auxiliary status byte bits
	localparam int SDHCS_AUX_INDEX = 0;
	localparam int SDHCS_AUX_WRAP = 1;
	localparam int SDHCS_AUX_LOOP_ON = 2;
	localparam int SDHCS_AUX_RAMP_DONE = 3;
	localparam int SDHCS_AUX_SLEW_DONE = 4;
	localparam int SDHCS_AUX_OVERRUN = 5;
	localparam int SDHCS_AUX_PATH = 6;
	// Diagnostic register fields
	localparam int SDHCS_DIAG_EN = 0;
	localparam int SDHCS_DIAG_POWER = 1;
	localparam int SDHCS_DIAG_HOME_SRC = 2;
	localparam int SDHCS_DIAG_LIMIT = 3;
	localparam int SDHCS_DIAG_INDEX = 4;
	// Command register fields
	localparam int SDHCS_CMDREG_PENDING = 16;

	typedef enum logic [1:0] {
		SDHCS_RX_IDLE = 2'b00,
		SDHCS_RX_START = 2'b01,
		SDHCS_RX_DATA = 2'b10,
		SDHCS_RX_STOP = 2'b11
	} sdhcs_rx_t;

	typedef enum logic [2:0] {
		SDHCS_P_HDR = 3'b000,
		SDHCS_P_ADDR = 3'b001,
		SDHCS_P_CMD = 3'b010,
		SDHCS_P_DATA = 3'b011,
		SDHCS_P_SUM = 3'b100
	} sdhcs_parse_t;
endpackage

// file: rtl/sdhcs_top.sv
// Command packet receiver, status reporter and APB register file of a
// networked single-axis servo drive.
// Assumes the motion core shares clk and drives its inputs as single-cycle
// events or levels; serial pins are asynchronous and resynchronised here.
// Function
// R01 - Hard reset returns all state to power-up and sends no reply; here the receiver, tick counter and data bytes are not reset by it.
// R02 - Hard reset to address FF resets regardless of group address.
// R03 - Status bit 0 low during profile move or acceleration, else high.
// R04 - Status bit 1 set when last received packet failed checksum.
// R05 - Status bit 2 set on current limit, held until sticky clear.
// R06 - Status bit 4 set on position error or servo off, sticky.
// R07 - Status bit 7 high during home search, zero once captured.
// R08 - Status bits 3,5,6 show power, home source, forward limit or diagnostics.
// R09 - Aux bit 0 is inverted index input or a diagnostic value.
// R10 - Aux bit 1 set on position counter wrap, held until sticky clear.
// R11 - Aux bit 2 high exactly while the position servo is enabled.
// R12 - Aux bit 3 set at end of ramp-up, cleared at next move.
// R13 - Aux bit 4 set at end of constant speed, cleared at next move.
// R14 - Aux bit 5 set when a tick's processing overruns, sticky.
// R15 - Aux bit 6 high during path; cleared by empty, stop or load.
// R16 - Host hard-resets, addresses, then loads nonzero gain, limit, rate.
// R17 - Initial load trajectory only initialises registers, starts no motion.
// R18 - Host closes the loop last with stop motor, amp enable, abrupt.
// R19 - Drive only replies when addressed; never transmits unprompted.
// R20 - All serial bytes travel least significant bit first.
// R21 - Packet: header AA, address, command byte, data, checksum.
// R22 - Checksum sums address, command and data, not the header.
// R23 - Default reply is status byte then checksum of status bytes.
// R24 - Sticky flags clear only with the sticky-clear command.
// R25 - Individual addresses 01h-7Fh, group addresses 80h-FFh.
// R26 - Checksum keeps low eight bits of the sum, carry dropped.
`timescale 1ns/10ps
module sdhcs_top (
	input wire logic clk,
	input wire logic reset_n,
	// APB slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial link pins
	input wire logic rx_pin,
	output logic tx_pin,
	output logic tx_oe,
	// Drive input pins
	input wire logic index_pin,
	input wire logic limit_fwd_pin,
	// Motion core, same clock
	input wire logic profile_busy,
	input wire logic servo_enabled,
	input wire logic home_source,
	input wire logic calc_busy,
	input wire logic overcurrent_evt,
	input wire logic pos_error_evt,
	input wire logic counter_wrap_evt,
	input wire logic ramp_done_evt,
	input wire logic slew_done_evt,
	input wire logic home_captured_evt,
	input wire logic path_empty_evt,
	output logic hard_reset_pulse,
	output logic move_start,
	output logic traj_init_only
);
	import sdhcs_pkg::*;

	function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] off);
		reg_hit = (a == off);
	endfunction

	logic rx_s1, rx_s2, idx_s1, idx_s2, lim_s1, lim_s2;
	sdhcs_rx_t rx_state;
	logic [5:0] rx_cnt;
	logic [2:0] rx_bit;
	logic [7:0] rx_sh;
	logic rx_valid;
	sdhcs_parse_t p_state;
	logic [7:0] p_addr, p_cmd, p_sum;
	logic [3:0] p_idx;
	logic [7:0] p_data [0:14];
	logic pkt_done, pkt_ok;
	logic [7:0] indiv_addr, group_addr;
	logic [4:0] diag;
	logic srst;
	logic is_mine, reply_me, exec;
	logic [3:0] code;
	logic clr_sticky, do_stop_load;
	logic f_cksum, f_overcur, f_follow, f_wrap, f_ramp, f_slew, f_overrun, f_homing, f_path;
	logic [7:0] status_byte, aux_byte;
	logic [11:0] tick_cnt;
	logic cmd_pending;
	logic [7:0] cmd_addr, cmd_byte;
	logic [9:0] tx_sh;
	logic [3:0] tx_bits;
	logic [5:0] tx_cnt;
	logic [7:0] tx_second;
	logic tx_more, reply_req;
	logic [31:0] next_prdata;

	// Pins are asynchronous to clk
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			idx_s1 <= 1'b0;
			idx_s2 <= 1'b0;
			lim_s1 <= 1'b0;
			lim_s2 <= 1'b0;
		end else begin
			rx_s1 <= rx_pin;
			rx_s2 <= rx_s1;
			idx_s1 <= index_pin;
			idx_s2 <= idx_s1;
			lim_s1 <= limit_fwd_pin;
			lim_s2 <= lim_s1;
		end
	end

	// Receiver: start bit, eight data bits LSB first, stop bit
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_state <= SDHCS_RX_IDLE;
			rx_cnt <= 6'h00;
			rx_bit <= 3'h0;
			rx_sh <= 8'h00;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			unique case (rx_state)
				SDHCS_RX_IDLE: begin
					if (!rx_s2) begin
						rx_cnt <= 6'(SDHCS_HALF_CYC - 1);
						rx_state <= SDHCS_RX_START;
					end
				end
				SDHCS_RX_START: begin
					if (rx_cnt != 6'h00) begin
						rx_cnt <= rx_cnt - 6'h01;
					end else if (!rx_s2) begin
						rx_cnt <= 6'(SDHCS_BIT_CYC - 1);
						rx_bit <= 3'h0;
						rx_state <= SDHCS_RX_DATA;
					end else begin
						rx_state <= SDHCS_RX_IDLE;
					end
				end
				SDHCS_RX_DATA: begin
					if (rx_cnt != 6'h00) begin
						rx_cnt <= rx_cnt - 6'h01;
					end else begin
						rx_sh <= {rx_s2, rx_sh[7:1]}; // R20
						rx_cnt <= 6'(SDHCS_BIT_CYC - 1);
						rx_bit <= rx_bit + 3'h1;
						if (rx_bit == 3'h7) begin
							rx_state <= SDHCS_RX_STOP;
						end
					end
				end
				SDHCS_RX_STOP: begin
					if (rx_cnt != 6'h00) begin
						rx_cnt <= rx_cnt - 6'h01;
					end else begin
						// Framing errors drop the byte silently
						rx_valid <= rx_s2;
						rx_state <= SDHCS_RX_IDLE;
					end
				end
			endcase
		end
	end

	// Packet parser
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			p_state <= SDHCS_P_HDR;
			p_addr <= 8'h00;
			p_cmd <= 8'h00;
			p_sum <= 8'h00;
			p_idx <= 4'h0;
			pkt_done <= 1'b0;
			pkt_ok <= 1'b0;
		end else begin
			pkt_done <= 1'b0;
			if (srst) begin
				p_state <= SDHCS_P_HDR; // R01
				p_addr <= 8'h00;
				p_cmd <= 8'h00;
			end else if (rx_valid) begin
				unique case (p_state)
					SDHCS_P_HDR: begin
						if (rx_sh == SDHCS_HEADER) begin // R21
							p_state <= SDHCS_P_ADDR;
						end
					end
					SDHCS_P_ADDR: begin
						p_addr <= rx_sh;
						p_sum <= rx_sh; // R22
						p_state <= SDHCS_P_CMD;
					end
					SDHCS_P_CMD: begin
						p_cmd <= rx_sh;
						p_sum <= p_sum + rx_sh; // R26
						p_idx <= 4'h0;
						p_state <= (rx_sh[7:4] == 4'h0) ? SDHCS_P_SUM : SDHCS_P_DATA; // R21
					end
					SDHCS_P_DATA: begin
						p_sum <= p_sum + rx_sh; // R22
						p_idx <= p_idx + 4'h1;
						if (p_idx == p_cmd[7:4] - 4'h1) begin
							p_state <= SDHCS_P_SUM;
						end
					end
					SDHCS_P_SUM: begin
						pkt_ok <= (p_sum == rx_sh); // R26
						pkt_done <= 1'b1;
						p_state <= SDHCS_P_HDR;
					end
					default: p_state <= SDHCS_P_HDR;
				endcase
			end
		end
	end

	// Data bytes need no reset; software reads them only after a packet
	always_ff @(posedge clk) begin
		if (rx_valid && p_state == SDHCS_P_DATA) begin
			p_data[p_idx] <= rx_sh;
		end
	end

	// Address match and command dispatch
	assign code = p_cmd[3:0];
	always_comb begin
		is_mine = (p_addr == indiv_addr) || (p_addr == group_addr); // R25
		if (p_addr == SDHCS_ADDR_ALL && code == SDHCS_CMD_HARD_RESET) begin
			is_mine = 1'b1; // R02
		end
		// Group leader answers for its group
		reply_me = (p_addr == indiv_addr) ||
			(p_addr == group_addr && indiv_addr == group_addr - SDHCS_GROUP_BASE);
		if (code == SDHCS_CMD_HARD_RESET) begin
			reply_me = 1'b0; // R01
		end
	end
	assign exec = pkt_done && pkt_ok && is_mine;
	assign clr_sticky = exec && code == SDHCS_CMD_CLR_STICKY; // R24
	assign do_stop_load = exec && (code == SDHCS_CMD_STOP || code == SDHCS_CMD_LOAD_TRAJ);

	// Hard reset pulse and move start
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			srst <= 1'b0;
			move_start <= 1'b0;
			traj_init_only <= 1'b0;
			reply_req <= 1'b0;
		end else begin
			srst <= exec && code == SDHCS_CMD_HARD_RESET; // R01
			// Load trajectory with loop still open only primes registers
			move_start <= exec && code == SDHCS_CMD_LOAD_TRAJ && servo_enabled; // R17
			traj_init_only <= exec && code == SDHCS_CMD_LOAD_TRAJ && !servo_enabled; // R17
			reply_req <= pkt_done && is_mine && reply_me; // R19
		end
	end
	assign hard_reset_pulse = srst;

	// Servo tick and overrun detection
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_cnt <= 12'h000;
		end else if (tick_cnt == 12'(SDHCS_TICK_CYC - 1)) begin
			tick_cnt <= 12'h000;
		end else begin
			tick_cnt <= tick_cnt + 12'h001;
		end
	end

	// Sticky and event flags; a set in the clearing cycle wins
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			f_cksum <= 1'b0;
			f_overcur <= 1'b0;
			f_follow <= 1'b0;
			f_wrap <= 1'b0;
			f_overrun <= 1'b0;
		end else if (srst) begin
			f_cksum <= 1'b0; // R01
			f_overcur <= 1'b0;
			f_follow <= 1'b0;
			f_wrap <= 1'b0;
			f_overrun <= 1'b0;
		end else begin
			if (pkt_done && is_mine) begin
				f_cksum <= !pkt_ok; // R04
			end
			f_overcur <= overcurrent_evt | (f_overcur & ~clr_sticky); // R05
			f_follow <= pos_error_evt | ~servo_enabled | (f_follow & ~clr_sticky); // R06
			f_wrap <= counter_wrap_evt | (f_wrap & ~clr_sticky); // R10
			f_overrun <= (tick_cnt == 12'(SDHCS_TICK_CYC - 1) && calc_busy) |
				(f_overrun & ~clr_sticky); // R14
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			f_ramp <= 1'b0;
			f_slew <= 1'b0;
			f_homing <= 1'b0;
			f_path <= 1'b0;
		end else if (srst) begin
			f_ramp <= 1'b0;
			f_slew <= 1'b0;
			f_homing <= 1'b0;
			f_path <= 1'b0;
		end else begin
			f_ramp <= ramp_done_evt | (f_ramp & ~move_start); // R12
			f_slew <= slew_done_evt | (f_slew & ~move_start); // R13
			f_homing <= (exec && code == SDHCS_CMD_HOMING) |
				(f_homing & ~home_captured_evt); // R07
			f_path <= (exec && code == SDHCS_CMD_PATH && p_cmd[7:4] == 4'h0) |
				(f_path & ~path_empty_evt & ~do_stop_load); // R15
		end
	end

	always_comb begin
		status_byte[SDHCS_ST_MOTION_DONE] = !profile_busy; // R03
		status_byte[SDHCS_ST_CKSUM] = f_cksum;
		status_byte[SDHCS_ST_OVERCURRENT] = f_overcur;
		status_byte[SDHCS_ST_POWER] = diag[SDHCS_DIAG_EN] ? diag[SDHCS_DIAG_POWER] :
			servo_enabled; // R08
		status_byte[SDHCS_ST_FOLLOW_ERR] = f_follow;
		status_byte[SDHCS_ST_HOME_SRC] = diag[SDHCS_DIAG_EN] ? diag[SDHCS_DIAG_HOME_SRC] :
			home_source; // R08
		status_byte[SDHCS_ST_LIMIT_FWD] = diag[SDHCS_DIAG_EN] ? diag[SDHCS_DIAG_LIMIT] :
			lim_s2; // R08
		status_byte[SDHCS_ST_HOMING] = f_homing;
		aux_byte[SDHCS_AUX_INDEX] = diag[SDHCS_DIAG_EN] ? diag[SDHCS_DIAG_INDEX] : !idx_s2; // R09
		aux_byte[SDHCS_AUX_WRAP] = f_wrap;
		aux_byte[SDHCS_AUX_LOOP_ON] = servo_enabled; // R11
		aux_byte[SDHCS_AUX_RAMP_DONE] = f_ramp;
		aux_byte[SDHCS_AUX_SLEW_DONE] = f_slew;
		aux_byte[SDHCS_AUX_OVERRUN] = f_overrun;
		aux_byte[SDHCS_AUX_PATH] = f_path;
		aux_byte[7] = 1'b0;
	end

	// Reply transmitter: status byte then its checksum
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_sh <= 10'h3ff;
			tx_bits <= 4'h0;
			tx_cnt <= 6'h00;
			tx_second <= 8'h00;
			tx_more <= 1'b0;
		end else if (tx_bits == 4'h0) begin
			if (reply_req) begin
				tx_sh <= {1'b1, status_byte, 1'b0};
				// Sum of status byte alone in the default format
				tx_second <= status_byte; // R23
				tx_more <= 1'b1;
				tx_bits <= 4'ha;
				tx_cnt <= 6'(SDHCS_BIT_CYC - 1);
			end else if (tx_more) begin
				tx_sh <= {1'b1, tx_second, 1'b0};
				tx_more <= 1'b0;
				tx_bits <= 4'ha;
				tx_cnt <= 6'(SDHCS_BIT_CYC - 1);
			end
		end else if (tx_cnt != 6'h00) begin
			tx_cnt <= tx_cnt - 6'h01;
		end else begin
			tx_sh <= {1'b1, tx_sh[9:1]}; // R20
			tx_bits <= tx_bits - 4'h1;
			tx_cnt <= 6'(SDHCS_BIT_CYC - 1);
		end
	end
	// Line driver stays off between replies so other drives can answer
	assign tx_pin = (tx_bits == 4'h0) ? 1'b1 : tx_sh[0];
	assign tx_oe = (tx_bits != 4'h0);

	// Software-visible address, diagnostics and last command
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			indiv_addr <= SDHCS_ADDR_RST[7:0];
			group_addr <= SDHCS_ADDR_RST[15:8];
			diag <= SDHCS_DIAG_RST;
		end else if (srst) begin
			indiv_addr <= SDHCS_ADDR_RST[7:0]; // R01
			group_addr <= SDHCS_ADDR_RST[15:8];
			diag <= SDHCS_DIAG_RST;
		end else if (psel && penable && pwrite) begin
			if (reg_hit(paddr, SDHCS_REG_ADDR)) begin
				indiv_addr <= pwdata[7:0];
				group_addr <= pwdata[15:8];
			end
			if (reg_hit(paddr, SDHCS_REG_DIAG)) begin
				diag <= pwdata[4:0];
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_pending <= 1'b0;
			cmd_addr <= 8'h00;
			cmd_byte <= 8'h00;
		end else if (srst) begin
			cmd_pending <= 1'b0; // R01
			cmd_addr <= 8'h00;
			cmd_byte <= 8'h00;
		end else if (exec && code != SDHCS_CMD_HARD_RESET) begin
			cmd_pending <= 1'b1;
			cmd_addr <= p_addr;
			cmd_byte <= p_cmd;
		end else if (psel && penable && pwrite && reg_hit(paddr, SDHCS_REG_CMD) &&
			pwdata[SDHCS_CMDREG_PENDING]) begin
			cmd_pending <= 1'b0;
		end
	end

	// Read data is captured in the setup cycle; zero wait states
	always_comb begin
		next_prdata = 32'h0000_0000;
		if (reg_hit(paddr, SDHCS_REG_STATUS)) begin
			next_prdata = {16'h0000, aux_byte, status_byte};
		end else if (reg_hit(paddr, SDHCS_REG_ADDR)) begin
			next_prdata = {16'h0000, group_addr, indiv_addr};
		end else if (reg_hit(paddr, SDHCS_REG_DIAG)) begin
			next_prdata = {27'h0000000, diag};
		end else if (reg_hit(paddr, SDHCS_REG_CMD)) begin
			next_prdata = {15'h0000, cmd_pending, cmd_addr, cmd_byte};
		end else if (paddr >= SDHCS_REG_DATA0 && paddr <= SDHCS_REG_DATA3 &&
			paddr[1:0] == 2'b00) begin
			unique case (paddr[3:2])
				2'b00: next_prdata = {p_data[3], p_data[2], p_data[1], p_data[0]};
				2'b01: next_prdata = {p_data[7], p_data[6], p_data[5], p_data[4]};
				2'b10: next_prdata = {p_data[11], p_data[10], p_data[9], p_data[8]};
				2'b11: next_prdata = {8'h00, p_data[14], p_data[13], p_data[12]};
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			prdata <= next_prdata;
			pslverr <= !(reg_hit(paddr, SDHCS_REG_STATUS) || reg_hit(paddr, SDHCS_REG_ADDR) ||
				reg_hit(paddr, SDHCS_REG_DIAG) || reg_hit(paddr, SDHCS_REG_CMD) ||
				(paddr >= SDHCS_REG_DATA0 && paddr <= SDHCS_REG_DATA3 && paddr[1:0] == 2'b00));
		end
	end
	assign pready = 1'b1;
endmodule // sdhcs_top

// file: verif/sdhcs_asserts.sv
// Checker for the servo drive command and status block.
// Sees only ports of sdhcs_top; bound to every instance of it.
`timescale 1ns/10ps
module sdhcs_asserts (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic rx_pin,
	input wire logic tx_pin,
	input wire logic tx_oe,
	input wire logic profile_busy,
	input wire logic servo_enabled,
	input wire logic hard_reset_pulse,
	input wire logic move_start,
	input wire logic traj_init_only
);
	import sdhcs_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic [9:0] oe_run;
	logic [9:0] rx_quiet;
	logic st_rd;
	assign st_rd = psel && !penable && !pwrite && paddr == SDHCS_REG_STATUS;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			oe_run <= 10'h000;
		end else begin
			oe_run <= tx_oe ? oe_run + 10'h001 : 10'h000;
		end
	end
	// Saturates so a silent link never looks like fresh traffic
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_quiet <= 10'h3ff;
		end else if (!rx_pin) begin
			rx_quiet <= 10'h000;
		end else if (rx_quiet != 10'h3ff) begin
			rx_quiet <= rx_quiet + 10'h001;
		end
	end
	a_tx_idle_high: assert property (!tx_oe |-> tx_pin)
		else $error("tx line low while driver off");
	a_start_bit_low: assert property ($rose(tx_oe) |-> !tx_pin [*8])
		else $error("reply frame without start bit");
	a_frame_length: assert property (oe_run <= 10'd320)
		else $error("reply frame longer than ten bits");
	a_no_unprompted: assert property ($rose(tx_oe) && !$past(tx_oe, 2) |-> rx_quiet < 10'd400)
		else $error("reply without a preceding command");
	a_reset_silent: assert property (hard_reset_pulse |-> !tx_oe [*8])
		else $error("reply after hard reset");
	a_move_done_lvl: assert property (st_rd && $stable(profile_busy)
		&& profile_busy == $past(profile_busy, 2) |=> prdata[0] == !$past(profile_busy))
		else $error("motion complete bit wrong");
	a_loop_on_lvl: assert property (st_rd && $stable(servo_enabled)
		&& servo_enabled == $past(servo_enabled, 2) |=> prdata[10] == $past(servo_enabled))
		else $error("loop enabled bit wrong");
	a_follow_off: assert property (st_rd && !servo_enabled && !$past(servo_enabled)
		&& !$past(servo_enabled, 2) |=> prdata[4])
		else $error("following error clear with servo off");
	a_init_still: assert property (traj_init_only |-> !move_start && !$past(servo_enabled))
		else $error("initial trajectory started motion");
	a_move_servo: assert property (move_start |-> $past(servo_enabled) && !traj_init_only)
		else $error("motion started with servo off");
endmodule // sdhcs_asserts

bind sdhcs_top sdhcs_asserts sdhcs_asserts_i (.clk(clk), .reset_n(reset_n), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .rx_pin(rx_pin),
	.tx_pin(tx_pin), .tx_oe(tx_oe), .profile_busy(profile_busy), .servo_enabled(servo_enabled),
	.hard_reset_pulse(hard_reset_pulse), .move_start(move_start),
	.traj_init_only(traj_init_only));

// file: verif/sdhcs_host_model.sv
// Host master model on the drive's serial link: sends framed commands
// and collects the status reply. Assumes 8N1 at 32 clocks per bit.
`timescale 1ns/10ps
module sdhcs_host_model (
	input wire logic clk,
	output logic rx_pin,
	input wire logic tx_pin,
	input wire logic tx_oe
);
	initial rx_pin = 1'b1;
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk) rx_pin <= fr[i];
			repeat (31) @(posedge clk);
		end
	endtask
	// Only 0 or 1 data bytes; bad corrupts the checksum on purpose
	task automatic send_pkt(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d,
		input bit bad);
		logic [7:0] sum;
		sum = a + c;
		send_byte(8'haa);
		send_byte(a);
		send_byte(c);
		if (c[7:4] != 4'h0) begin
			sum = sum + d;
			send_byte(d);
		end
		send_byte(bad ? sum + 8'h01 : sum);
	endtask
	task automatic get_byte(output logic got, output logic [7:0] b);
		int n;
		n = 0;
		b = 8'h00;
		while (!(tx_oe === 1'b1 && tx_pin === 1'b0) && n < 1000) begin
			@(posedge clk);
			n++;
		end
		got = (n < 1000);
		if (!got) return;
		repeat (16) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (32) @(posedge clk);
			b[i] = tx_pin;
		end
		repeat (32) @(posedge clk);
	endtask
	task automatic get_reply(output logic got, output logic [7:0] b0, output logic [7:0] b1);
		b1 = 8'h00;
		get_byte(got, b0);
		if (got) get_byte(got, b1);
	endtask
endmodule // sdhcs_host_model

// file: verif/tb_top.sv
// Self-checking bench for sdhcs_top: APB master, host link model and
// motion-core stimulus, all on the one 40 MHz clock.
`timescale 1ns/10ps
module tb_top;
	import sdhcs_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rv;
	logic pready, pslverr, re, rx_pin, tx_pin, tx_oe;
	// Levels: index, forward limit, profile busy, servo on, home source
	logic [4:0] lv = 5'h00;
	logic [6:0] ev = 7'h00;
	logic calc_busy = 1'b0;
	logic hard_reset_pulse, move_start, traj_init_only;
	logic [2:0] saw = 3'b000;
	logic [15:0] st;
	logic [7:0] rb;
	int mismatches = 0;
	int checks_done = 0;
	always #12.5 clk = ~clk;
	sdhcs_top sdhcs_top_i (.clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_pin(rx_pin), .tx_pin(tx_pin), .tx_oe(tx_oe), .index_pin(lv[0]),
		.limit_fwd_pin(lv[1]), .profile_busy(lv[2]), .servo_enabled(lv[3]),
		.home_source(lv[4]), .calc_busy(calc_busy), .overcurrent_evt(ev[0]),
		.pos_error_evt(ev[1]), .counter_wrap_evt(ev[2]), .ramp_done_evt(ev[3]),
		.slew_done_evt(ev[4]), .home_captured_evt(ev[5]), .path_empty_evt(ev[6]),
		.hard_reset_pulse(hard_reset_pulse), .move_start(move_start),
		.traj_init_only(traj_init_only));
	sdhcs_host_model sdhcs_host_model_i (.clk(clk), .rx_pin(rx_pin), .tx_pin(tx_pin),
		.tx_oe(tx_oe));
	always @(posedge clk) begin
		if (hard_reset_pulse) saw[2] <= 1'b1;
		if (traj_init_only) saw[1] <= 1'b1;
		if (move_start) saw[0] <= 1'b1;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	// Settle time lets the synchronisers and status flops catch up
	task automatic rd_st;
		repeat (4) @(posedge clk);
		rd(SDHCS_REG_STATUS);
		st = rv[15:0];
	endtask
	task automatic pulse(input int i);
		@(posedge clk) ev[i] <= 1'b1;
		@(posedge clk) ev[i] <= 1'b0;
	endtask
	task automatic set_lv(input logic [4:0] v);
		@(posedge clk) lv <= v;
	endtask
	task automatic xfer(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d,
		input bit bad, input logic want);
		logic got;
		logic [7:0] b1;
		sdhcs_host_model_i.send_pkt(a, c, d, bad);
		sdhcs_host_model_i.get_reply(got, rb, b1);
		chk(got, want);
		if (got) chk(b1, rb);
	endtask
	task automatic t_regs;
		rd(SDHCS_REG_ADDR);
		chk(rv, 32'h0);
		rd(SDHCS_REG_DIAG);
		chk(rv, 32'h0);
		rd(12'h020);
		chk({re, rv[30:0]}, 32'h80000000);
		rd(12'h002);
		chk(re, 1'b1);
		wr(SDHCS_REG_ADDR, 32'h0000ff01);
		rd(SDHCS_REG_ADDR);
		chk(rv, 32'h0000ff01);
	endtask
	task automatic t_levels;
		rd_st;
		chk({st[10], st[8], st[4], st[0]}, 4'h7);
		set_lv(5'h1f);
		rd_st;
		chk({st[10], st[8], st[0]}, 3'h4);
		chk({st[6], st[5], st[3]}, 3'h7);
		wr(SDHCS_REG_DIAG, 32'h11);
		rd_st;
		chk({st[8], st[6], st[5], st[3]}, 4'h8);
		wr(SDHCS_REG_DIAG, 32'h0);
		set_lv(5'h0a);
		rd_st;
		chk({st[6], st[5], st[0]}, 3'h5);
	endtask
	task automatic t_sticky;
		xfer(8'h01, 8'h0b, 8'h00, 1'b0, 1'b1);
		rd_st;
		chk(st[4], 1'b0);
		pulse(0);
		pulse(1);
		pulse(2);
		@(posedge clk) calc_busy <= 1'b1;
		repeat (2100) @(posedge clk);
		calc_busy <= 1'b0;
		rd_st;
		chk({st[13], st[9], st[4], st[2]}, 4'hf);
		xfer(8'h01, 8'h0b, 8'h00, 1'b0, 1'b1);
		rd_st;
		chk({st[13], st[9], st[4], st[2]}, 4'h0);
	endtask
	task automatic t_motion;
		pulse(3);
		pulse(4);
		xfer(8'h01, 8'h0d, 8'h00, 1'b0, 1'b1);
		rd_st;
		chk({st[14], st[12], st[11]}, 3'h7);
		@(posedge clk) saw <= 3'b000;
		xfer(8'h01, 8'h14, 8'h00, 1'b0, 1'b1);
		rd_st;
		chk({st[14], st[12], st[11]}, 3'h0);
		chk(saw, 3'b001);
		xfer(8'h01, 8'h0d, 8'h00, 1'b0, 1'b1);
		pulse(6);
		rd_st;
		chk(st[14], 1'b0);
		xfer(8'h01, 8'h0d, 8'h00, 1'b0, 1'b1);
		xfer(8'h01, 8'h17, 8'h05, 1'b0, 1'b1);
		rd_st;
		chk(st[14], 1'b0);
		xfer(8'h01, 8'h19, 8'h00, 1'b0, 1'b1);
		rd_st;
		chk(st[7], 1'b1);
		pulse(5);
		rd_st;
		chk(st[7], 1'b0);
	endtask
	task automatic t_init;
		set_lv(5'h00);
		@(posedge clk) saw <= 3'b000;
		xfer(8'h01, 8'h14, 8'hf0, 1'b0, 1'b1);
		chk(saw, 3'b010);
		rd(SDHCS_REG_DATA0);
		chk(rv[7:0], 8'hf0);
		rd_st;
		chk(st[1], 1'b0);
	endtask
	task automatic t_cksum;
		xfer(8'h01, 8'h0e, 8'h00, 1'b1, 1'b1);
		rd_st;
		chk(st[1], 1'b1);
		chk(rb, 8'h13);
		xfer(8'h01, 8'h0e, 8'h00, 1'b0, 1'b1);
		rd_st;
		chk(st[1], 1'b0);
		rd(SDHCS_REG_CMD);
		chk(rv, 32'h0001010e);
		wr(SDHCS_REG_CMD, 32'h00010000);
		rd(SDHCS_REG_CMD);
		chk(rv, 32'h0000010e);
		xfer(8'h02, 8'h0e, 8'h00, 1'b0, 1'b0);
	endtask
	task automatic t_reset;
		wr(SDHCS_REG_ADDR, 32'h00008101);
		// Individual 01 leads group 81, so it answers
		xfer(8'h81, 8'h0e, 8'h00, 1'b0, 1'b1);
		pulse(0);
		@(posedge clk) saw <= 3'b000;
		xfer(8'hff, 8'h0f, 8'h00, 1'b0, 1'b0);
		chk(saw[2], 1'b1);
		rd(SDHCS_REG_ADDR);
		chk(rv, 32'h0);
		rd_st;
		chk(st[2], 1'b0);
		rd(SDHCS_REG_CMD);
		chk(rv, 32'h0);
		wr(SDHCS_REG_ADDR, 32'h0000ff01);
		rd(SDHCS_REG_ADDR);
		chk(rv, 32'h0000ff01);
	endtask
	task automatic final_report;
		$display("Checks %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		t_regs;
		t_levels;
		t_sticky;
		t_motion;
		t_init;
		t_cksum;
		t_reset;
		final_report;
	end
	// Roughly three times the expected run length
	initial begin
		#2400000;
		mismatches++;
		final_report;
	end
endmodule // tb_top
